// File: hdl/lpt_pkg.sv
package lpt_pkg;
    localparam int NUM_BANKS = 4;
    localparam int DATA_W = 12;
    localparam int LANE_W = 13;
    localparam int PAT_DEPTH = 8;
    localparam int PTR_W = 3;
    localparam int REG_AW = 12;
    localparam int REG_DW = 16;

    localparam logic [11:0] ADDR_CONFIG = 12'h710;
    localparam logic [11:0] ADDR_CONTROL = 12'h711;
    localparam logic [11:0] ADDR_SUMMARY = 12'h712;
    localparam logic [11:0] ADDR_PATTERN = 12'h720;
    localparam logic [11:0] ADDR_STATUS = 12'h750;
    localparam logic [11:0] ADDR_STEP = 12'h002;

    localparam int CFG_ENABLE_LSB = 4;
    localparam int CFG_LOCK_BIT = 1;
    localparam int CFG_CONT_BIT = 0;
    localparam int CTRL_TRIG_BIT = 0;
    localparam int LANE_STROBE_BIT = 12;

    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [15:0] PATTERN_RESET = 16'h0000;

    typedef enum logic [1:0] {
        LPT_IDLE = 2'b00,
        LPT_ARMED = 2'b01,
        LPT_RUNNING = 2'b10,
        LPT_HALTED = 2'b11
    } lpt_state_type;
endpackage

// File: hdl/lpt_bank_checker.sv
`timescale 1ns/10ps
module lpt_bank_checker (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_link_clk,
    input wire logic [lpt_pkg::DATA_W-1:0] i_data,
    input wire logic i_strobe,
    input wire logic i_enable,
    input wire logic i_trigger,
    input wire logic i_trig_start,
    input wire logic i_cont,
    input wire logic i_lock,
    input wire logic [lpt_pkg::LANE_W-1:0] i_clr_mask,
    input wire logic [lpt_pkg::PAT_DEPTH*lpt_pkg::LANE_W-1:0] i_pattern,
    output logic [lpt_pkg::LANE_W-1:0] o_flags,
    output logic o_running,
    output logic o_alarm,
    output logic o_sample_valid,
    output logic [lpt_pkg::DATA_W-1:0] o_sample
);
    logic [lpt_pkg::LANE_W:0] sync1;
    logic [lpt_pkg::LANE_W:0] sync2;
    logic clk_prev;
    logic [lpt_pkg::PTR_W-1:0] ptr;
    lpt_pkg::lpt_state_type state;
    lpt_pkg::lpt_state_type next_state;

    // Both link clock edges carry a sample (DDR)
    wire link_edge = sync2[lpt_pkg::LANE_W] ^ clk_prev;
    wire [lpt_pkg::LANE_W-1:0] lanes = sync2[lpt_pkg::LANE_W-1:0];
    wire strobe_seen = lanes[lpt_pkg::LANE_STROBE_BIT];
    // RULE3: lock stops realign
    wire realign = strobe_seen && !i_lock;
    wire [lpt_pkg::PTR_W-1:0] idx = realign ? '0 : ptr;
    wire frame_start = link_edge && (idx == '0);
    wire [lpt_pkg::LANE_W-1:0] expected = i_pattern[idx*lpt_pkg::LANE_W +: lpt_pkg::LANE_W];
    // RULE16: per-lane compare
    // First sample of the arming frame is compared as well
    wire checking = (state == lpt_pkg::LPT_RUNNING && link_edge) || (state == lpt_pkg::LPT_ARMED && frame_start);
    wire [lpt_pkg::LANE_W-1:0] miss = checking ? (lanes ^ expected) : '0;
    wire any_miss = |miss;

    always_ff @(posedge i_clk_sys) begin
        // Two flops before the sampled lanes are used; link is not our clock
        sync1 <= {i_link_clk, i_strobe, i_data};
        sync2 <= sync1;
        clk_prev <= sync2[lpt_pkg::LANE_W];
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            ptr <= '0;
        end else if (link_edge) begin
            ptr <= idx + 3'd1;
        end
    end

    // RULE4: alarm regardless of lock
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_alarm <= 1'b0;
        end else begin
            o_alarm <= link_edge && strobe_seen && (ptr != '0);
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            lpt_pkg::LPT_IDLE: begin
                if (i_trig_start && i_enable) begin
                    next_state = lpt_pkg::LPT_ARMED;
                end
            end
            lpt_pkg::LPT_ARMED: begin
                // RULE7: start on frame boundary
                if (frame_start && any_miss && !i_cont) begin
                    next_state = lpt_pkg::LPT_HALTED;
                end else if (frame_start) begin
                    next_state = lpt_pkg::LPT_RUNNING;
                end
            end
            lpt_pkg::LPT_RUNNING: begin
                // RULE5: halt on first miss
                // RULE6: continuous keeps running
                if (any_miss && !i_cont) begin
                    next_state = lpt_pkg::LPT_HALTED;
                end
            end
            default: begin
                next_state = lpt_pkg::LPT_HALTED;
            end
        endcase
        // RULE9: trigger 0 stops
        // RULE1: only enabled banks run
        // Trigger byte still reads 0 on the edge that writes the 1
        if ((!i_trigger && !i_trig_start) || !i_enable) begin
            next_state = lpt_pkg::LPT_IDLE;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state <= lpt_pkg::LPT_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // RULE17: running drops, flags kept
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_running <= 1'b0;
        end else begin
            o_running <= (next_state == lpt_pkg::LPT_RUNNING);
        end
    end

    // RULE14: sticky flags, set beats clear
    // RULE8: trigger start clears all
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_flags <= '0;
        end else if (i_trig_start) begin
            o_flags <= '0;
        end else begin
            o_flags <= (o_flags & ~i_clr_mask) | miss;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_sample_valid <= 1'b0;
            o_sample <= '0;
        end else begin
            o_sample_valid <= link_edge;
            o_sample <= lanes[lpt_pkg::DATA_W-1:0];
        end
    end
endmodule // lpt_bank_checker

// File: hdl/lpt_pattern_check.sv
`timescale 1ns/10ps
// Summary of operation
// RULE1: Enable bits 7-4 start checking active banks
// RULE2: Any enable blocks data to converter
// RULE3: Strobe lock stops counter realignment
// RULE4: Strobe alarms still raised when locked
// RULE5: Continuous off halts on first mismatch
// RULE6: Continuous on runs until trigger cleared
// RULE7: Trigger zero-to-one starts at next frame
// RULE8: Same trigger write clears failure flags
// RULE9: Trigger written zero stops the test
// RULE10: Software reads running bits, not trigger
// RULE11: Config and control reset to zero
// RULE12: Read-only running bit per bank
// RULE13: Eight 16-bit pattern words, strobe bit 12
// RULE14: Per-bank write-one-to-clear mismatch flags
// RULE15: Summary bit follows any bank flag
// RULE16: Compare each sample, step words cyclically
// RULE17: Stop clears running, keeps flags
module lpt_pattern_check (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic [lpt_pkg::REG_AW-1:0] i_reg_addr,
    input wire logic [lpt_pkg::REG_DW-1:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [lpt_pkg::REG_DW-1:0] o_reg_rdata,
    output logic o_reg_rvalid,
    input wire logic [lpt_pkg::NUM_BANKS-1:0] i_bank_active,
    input wire logic i_link_clk,
    input wire logic [lpt_pkg::NUM_BANKS*lpt_pkg::DATA_W-1:0] i_lvds_data,
    input wire logic [lpt_pkg::NUM_BANKS-1:0] i_lvds_strobe,
    output logic [lpt_pkg::NUM_BANKS*lpt_pkg::DATA_W-1:0] o_conv_data,
    output logic [lpt_pkg::NUM_BANKS-1:0] o_conv_valid,
    output logic [lpt_pkg::NUM_BANKS-1:0] o_strobe_alarm
);
    localparam int NB = lpt_pkg::NUM_BANKS;
    localparam int LW = lpt_pkg::LANE_W;

    logic [7:0] config_reg;
    logic [7:0] control_reg;
    // RULE13: pattern memory
    logic [lpt_pkg::REG_DW-1:0] pattern_mem [lpt_pkg::PAT_DEPTH];
    logic [2:0] status_rsvd [NB];
    logic [NB-1:0] active_s1;
    logic [NB-1:0] active_s2;

    wire [LW-1:0] flags [NB];
    wire [NB-1:0] running;
    wire [NB-1:0] alarm;
    wire [NB-1:0] sample_valid;
    wire [lpt_pkg::DATA_W-1:0] sample [NB];
    wire [lpt_pkg::PAT_DEPTH*LW-1:0] pattern_flat;

    wire [NB-1:0] enable = config_reg[lpt_pkg::CFG_ENABLE_LSB +: NB];
    wire wr_config = i_reg_wr && (i_reg_addr == lpt_pkg::ADDR_CONFIG);
    wire wr_control = i_reg_wr && (i_reg_addr == lpt_pkg::ADDR_CONTROL);
    wire trigger = control_reg[lpt_pkg::CTRL_TRIG_BIT];
    // RULE7: zero-to-one trigger write
    wire trig_start = wr_control && i_reg_wdata[lpt_pkg::CTRL_TRIG_BIT] && !trigger;
    wire [lpt_pkg::REG_AW-1:0] pat_off = i_reg_addr - lpt_pkg::ADDR_PATTERN;
    wire [lpt_pkg::REG_AW-1:0] stat_off = i_reg_addr - lpt_pkg::ADDR_STATUS;
    wire pat_hit = (i_reg_addr >= lpt_pkg::ADDR_PATTERN) && (pat_off < 12'(2 * lpt_pkg::PAT_DEPTH)) && !pat_off[0];
    wire stat_hit = (i_reg_addr >= lpt_pkg::ADDR_STATUS) && (stat_off < 12'(2 * NB)) && !stat_off[0];
    wire [2:0] pat_idx = pat_off[3:1];
    wire [1:0] stat_idx = stat_off[2:1];
    wire [NB-1:0] summary;
    wire [7:0] summary_byte = {running, summary};

    genvar g;
    generate
        for (g = 0; g < lpt_pkg::PAT_DEPTH; g++) begin : g_pat
            assign pattern_flat[g*LW +: LW] = pattern_mem[g][LW-1:0];
        end
        for (g = 0; g < NB; g++) begin : g_bank
            wire wr_stat = i_reg_wr && stat_hit && (stat_idx == 2'(g));
            // RULE14: write one clears
            wire [LW-1:0] clr = wr_stat ? i_reg_wdata[LW-1:0] : '0;
            // RULE15: summary of bank flags
            assign summary[g] = |flags[g];

            lpt_bank_checker u_bank (
                .i_clk_sys(i_clk_sys),
                .i_rst(i_rst),
                .i_link_clk(i_link_clk),
                .i_data(i_lvds_data[g*lpt_pkg::DATA_W +: lpt_pkg::DATA_W]),
                .i_strobe(i_lvds_strobe[g]),
                .i_enable(enable[g] && active_s2[g]),
                .i_trigger(trigger),
                .i_trig_start(trig_start),
                .i_cont(config_reg[lpt_pkg::CFG_CONT_BIT]),
                .i_lock(config_reg[lpt_pkg::CFG_LOCK_BIT]),
                .i_clr_mask(clr),
                .i_pattern(pattern_flat),
                .o_flags(flags[g]),
                .o_running(running[g]),
                .o_alarm(alarm[g]),
                .o_sample_valid(sample_valid[g]),
                .o_sample(sample[g])
            );

            always_ff @(posedge i_clk_sys) begin
                if (i_rst) begin
                    status_rsvd[g] <= '0;
                end else if (wr_stat) begin
                    status_rsvd[g] <= i_reg_wdata[15:13];
                end
            end

            // RULE2: test blocks converter data
            always_ff @(posedge i_clk_sys) begin
                if (i_rst) begin
                    o_conv_data[g*lpt_pkg::DATA_W +: lpt_pkg::DATA_W] <= '0;
                    o_conv_valid[g] <= 1'b0;
                end else begin
                    o_conv_data[g*lpt_pkg::DATA_W +: lpt_pkg::DATA_W] <= (enable == '0) ? sample[g] : '0;
                    o_conv_valid[g] <= sample_valid[g] && (enable == '0);
                end
            end
        end
    endgenerate

    // Bank-active straps come from elsewhere; treat as asynchronous
    always_ff @(posedge i_clk_sys) begin
        active_s1 <= i_bank_active;
        active_s2 <= active_s1;
    end

    // RULE11: both bytes reset to zero
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            config_reg <= lpt_pkg::CONFIG_RESET;
            control_reg <= lpt_pkg::CONTROL_RESET;
        end else begin
            if (wr_config) begin
                config_reg <= i_reg_wdata[7:0];
            end
            if (wr_control) begin
                control_reg <= i_reg_wdata[7:0];
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            for (int i = 0; i < lpt_pkg::PAT_DEPTH; i++) begin
                pattern_mem[i] <= lpt_pkg::PATTERN_RESET;
            end
        end else if (i_reg_wr && pat_hit) begin
            pattern_mem[pat_idx] <= i_reg_wdata;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_strobe_alarm <= '0;
        end else begin
            o_strobe_alarm <= alarm;
        end
    end

    // RULE12: running bits readable
    wire [lpt_pkg::REG_DW-1:0] rd_mux =
        (i_reg_addr == lpt_pkg::ADDR_CONFIG) ? {8'h00, config_reg} :
        (i_reg_addr == lpt_pkg::ADDR_CONTROL) ? {8'h00, control_reg} :
        (i_reg_addr == lpt_pkg::ADDR_SUMMARY) ? {8'h00, summary_byte} :
        pat_hit ? pattern_mem[pat_idx] :
        stat_hit ? {status_rsvd[stat_idx], flags[stat_idx]} :
        16'h0000;

    // Read answers one cycle later; unmapped addresses return zero
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_reg_rdata <= '0;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rdata <= i_reg_rd ? rd_mux : o_reg_rdata;
            o_reg_rvalid <= i_reg_rd;
        end
    end
endmodule // lpt_pattern_check

// File: tb/lpt_check_assertions.sv
`timescale 1ns/10ps
module lpt_check_assertions (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic [11:0] i_reg_addr,
    input wire logic [15:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [15:0] o_reg_rdata,
    input wire logic [3:0] i_bank_active,
    input wire logic i_link_clk,
    input wire logic [47:0] o_conv_data,
    input wire logic [3:0] o_conv_valid,
    input wire logic [3:0] o_strobe_alarm
);
    logic [7:0] cfg;
    logic [7:0] ctl;
    logic seen;
    logic link_q;
    logic [3:0] age;
    wire cfg_wr = i_reg_wr && i_reg_addr == lpt_pkg::ADDR_CONFIG;
    wire ctl_wr = i_reg_wr && i_reg_addr == lpt_pkg::ADDR_CONTROL;
    wire rd_sum = i_reg_rd && i_reg_addr == lpt_pkg::ADDR_SUMMARY;
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);
    // Shadows judge readback from the writes alone
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            cfg <= 8'h00;
            ctl <= 8'h00;
            seen <= 1'b0;
            age <= 4'hf;
        end else begin
            if (cfg_wr) cfg <= i_reg_wdata[7:0];
            if (ctl_wr) ctl <= i_reg_wdata[7:0];
            if (cfg_wr || ctl_wr) seen <= 1'b1;
            age <= (link_q != i_link_clk) ? 4'h0 : age + {3'h0, age != 4'hf};
        end
        link_q <= i_link_clk;
    end
    a_block_conv_valid: assert property (cfg[7:4] != 0 && $past(cfg[7:4]) != 0 |-> o_conv_valid == 4'h0)
        else $error("converter valid while test enabled");
    a_block_conv_data: assert property (cfg[7:4] != 0 && $past(cfg[7:4]) != 0 |-> o_conv_data == 48'h0)
        else $error("converter data while test enabled");
    a_reset_reads_zero: assert property (i_reg_rd && !seen && (i_reg_addr == lpt_pkg::ADDR_CONFIG
        || i_reg_addr == lpt_pkg::ADDR_CONTROL) |=> o_reg_rdata[7:0] == 8'h00) else $error("reset value not zero");
    a_config_readback: assert property (i_reg_rd && i_reg_addr == lpt_pkg::ADDR_CONFIG && !cfg_wr
        |=> o_reg_rdata[7:0] == cfg) else $error("config readback wrong");
    a_trigger_readback: assert property (i_reg_rd && i_reg_addr == lpt_pkg::ADDR_CONTROL && !ctl_wr
        |=> o_reg_rdata[7:0] == ctl) else $error("control readback wrong");
    a_stop_clears_run: assert property (rd_sum && !ctl[0] && !$past(ctl[0]) |=> o_reg_rdata[7:4] == 4'h0)
        else $error("running with trigger low");
    a_run_needs_enable: assert property (rd_sum && cfg == $past(cfg) && cfg == $past(cfg, 2)
        |=> (o_reg_rdata[7:4] & ~(cfg[7:4] & i_bank_active)) == 4'h0) else $error("running bank not enabled");
    a_alarm_near_edge: assert property (o_strobe_alarm != 4'h0 |-> age <= 4'h8)
        else $error("alarm without link edge");
endmodule // lpt_check_assertions

// File: tb/lpt_fpga_model.sv
`timescale 1ns/10ps
module lpt_fpga_model (
    input wire logic i_clk_sys,
    input wire logic i_send,
    input wire logic [7:0][12:0] i_words,
    output logic o_link_clk,
    output logic [47:0] o_data,
    output logic [3:0] o_strobe,
    output logic o_busy
);
    initial begin
        o_link_clk = 1'b0;
        o_data = 48'h0;
        o_strobe = 4'h0;
        o_busy = 1'b0;
        forever begin
            @(posedge i_clk_sys);
            if (i_send) begin
                o_busy <= 1'b1;
                // Lanes settle two cycles before each edge, clock half period 80 ns
                for (int k = 0; k < 8; k++) begin
                    o_data <= {4{i_words[k][11:0]}};
                    o_strobe <= {4{i_words[k][12]}};
                    repeat (2) @(posedge i_clk_sys);
                    o_link_clk <= ~o_link_clk;
                    repeat (2) @(posedge i_clk_sys);
                end
                // Idle lanes invert, so a stale word never passes for a sample
                o_data <= ~o_data;
                o_strobe <= ~o_strobe;
                o_busy <= 1'b0;
            end
        end
    end
endmodule // lpt_fpga_model

// File: tb/testbench.sv
`timescale 1ns/10ps
module testbench;
    logic i_clk_sys;
    logic i_rst;
    logic [11:0] i_reg_addr;
    logic [15:0] i_reg_wdata;
    logic i_reg_wr;
    logic i_reg_rd;
    logic [15:0] o_reg_rdata;
    logic o_reg_rvalid;
    logic [3:0] i_bank_active;
    logic i_link_clk;
    logic [47:0] i_lvds_data;
    logic [3:0] i_lvds_strobe;
    logic [47:0] o_conv_data;
    logic [3:0] o_conv_valid;
    logic [3:0] o_strobe_alarm;
    logic send;
    logic busy;
    logic [7:0][12:0] frm;
    logic [7:0][12:0] pat;
    logic [7:0][12:0] bad;
    int mismatches;
    int check_count;
    int n_valid;
    int n_alarm;
    logic [11:0] conv_last;
    lpt_pattern_check u_dut (.i_clk_sys, .i_rst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
        .o_reg_rvalid, .i_bank_active, .i_link_clk, .i_lvds_data, .i_lvds_strobe, .o_conv_data, .o_conv_valid,
        .o_strobe_alarm);
    lpt_fpga_model u_fpga (.i_clk_sys, .i_send(send), .i_words(frm), .o_link_clk(i_link_clk),
        .o_data(i_lvds_data), .o_strobe(i_lvds_strobe), .o_busy(busy));
    initial begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end
    always @(posedge i_clk_sys) begin
        n_valid += o_conv_valid[0];
        n_alarm += o_strobe_alarm[0];
        if (o_conv_valid[0] === 1'b1) begin
            conv_last <= o_conv_data[11:0];
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [11:0] a, input logic [15:0] d);
        @(posedge i_clk_sys);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_reg_wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [11:0] a, input logic [15:0] exp);
        @(posedge i_clk_sys);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_reg_rd <= 1'b0;
        #1;
        check(o_reg_rvalid === 1'b1 ? o_reg_rdata : 16'hxxxx, exp);
    endtask
    task automatic run_frame(input logic [7:0][12:0] f);
        @(posedge i_clk_sys);
        frm <= f;
        send <= 1'b1;
        @(posedge i_clk_sys);
        send <= 1'b0;
        #1;
        for (int t = 0; t < 100 && busy; t++) @(posedge i_clk_sys);
        // Room for the lane synchronisers to drain
        repeat (8) @(posedge i_clk_sys);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #100000;
        mismatches++;
        complete_run();
    end
    initial begin
        i_rst = 1'b1;
        i_reg_addr = 12'h000;
        i_reg_wdata = 16'h0000;
        i_reg_wr = 1'b0;
        i_reg_rd = 1'b0;
        i_bank_active = 4'h7;
        send = 1'b0;
        frm = '0;
        mismatches = 0;
        check_count = 0;
        for (int k = 0; k < 8; k++) pat[k] = {k == 0, 12'h5a0 | 12'(k)};
        bad = pat;
        bad[3][5] = ~bad[3][5];
        repeat (12) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        rd_reg(lpt_pkg::ADDR_CONFIG, 16'h0000);
        rd_reg(lpt_pkg::ADDR_CONTROL, 16'h0000);
        for (int k = 0; k < 8; k++) wr_reg(lpt_pkg::ADDR_PATTERN + 12'(2 * k), {3'h0, pat[k]});
        rd_reg(lpt_pkg::ADDR_PATTERN + 12'h00e, {3'h0, pat[7]});
        rd_reg(lpt_pkg::ADDR_PATTERN + 12'h001, 16'h0000);
        n_valid = 0;
        run_frame(pat);
        check(16'(n_valid), 16'h0008);
        check({4'h0, conv_last}, {4'h0, pat[7][11:0]});
        $display("test reset and pattern done");
        wr_reg(lpt_pkg::ADDR_CONFIG, 16'h00f1);
        wr_reg(lpt_pkg::ADDR_CONTROL, 16'h0001);
        rd_reg(lpt_pkg::ADDR_CONFIG, 16'h00f1);
        rd_reg(lpt_pkg::ADDR_SUMMARY, 16'h0000);
        n_valid = 0;
        run_frame(pat);
        check(16'(n_valid), 16'h0000);
        rd_reg(lpt_pkg::ADDR_SUMMARY, 16'h0070);
        run_frame(bad);
        rd_reg(lpt_pkg::ADDR_SUMMARY, 16'h0077);
        rd_reg(lpt_pkg::ADDR_STATUS + 12'h002, 16'h0020);
        wr_reg(lpt_pkg::ADDR_STATUS, 16'h0020);
        rd_reg(lpt_pkg::ADDR_STATUS, 16'h0000);
        rd_reg(lpt_pkg::ADDR_SUMMARY, 16'h0076);
        wr_reg(lpt_pkg::ADDR_CONTROL, 16'h0000);
        rd_reg(lpt_pkg::ADDR_SUMMARY, 16'h0006);
        rd_reg(lpt_pkg::ADDR_STATUS + 12'h004, 16'h0020);
        $display("test continuous run done");
        wr_reg(lpt_pkg::ADDR_CONFIG, 16'h0030);
        wr_reg(lpt_pkg::ADDR_CONTROL, 16'h0001);
        rd_reg(lpt_pkg::ADDR_SUMMARY, 16'h0000);
        run_frame(pat);
        rd_reg(lpt_pkg::ADDR_SUMMARY, 16'h0030);
        run_frame(bad);
        rd_reg(lpt_pkg::ADDR_SUMMARY, 16'h0003);
        rd_reg(lpt_pkg::ADDR_CONTROL, 16'h0001);
        rd_reg(lpt_pkg::ADDR_STATUS, 16'h0020);
        $display("test stop on first miss done");
        wr_reg(lpt_pkg::ADDR_CONTROL, 16'h0000);
        bad = pat;
        bad[2][12] = 1'b1;
        wr_reg(lpt_pkg::ADDR_PATTERN + 12'h004, {3'h0, bad[2]});
        wr_reg(lpt_pkg::ADDR_CONFIG, 16'h0013);
        wr_reg(lpt_pkg::ADDR_CONTROL, 16'h0001);
        n_alarm = 0;
        run_frame(bad);
        rd_reg(lpt_pkg::ADDR_SUMMARY, 16'h0010);
        check(16'(n_alarm), 16'h0001);
        $display("test strobe lock done");
        complete_run();
    end
endmodule // testbench
bind lpt_pattern_check lpt_check_assertions u_chk (.i_clk_sys, .i_rst, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
    .i_reg_rd, .o_reg_rdata, .i_bank_active, .i_link_clk, .o_conv_data, .o_conv_valid, .o_strobe_alarm);
